// ### hdl/ext_bus_unit.sv
// external memory and port bus unit with clock outputs, test input and flag pin
`timescale 1ns/1ns
module ext_bus_unit
  import ext_bus_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // core request side
  input wire logic req_valid_i,
  input wire access_type req_kind_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic req_external_i,
  input wire logic req_repeat_i,
  input wire logic prog_external_i,
  input wire logic set_flag_instr_i,
  input wire logic clear_flag_instr_i,
  input wire logic branch_on_test_low_instr_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic branch_taken_o,
  // external pins
  output logic [15:0] addr_o,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic data_space_select_n_o,
  output logic program_space_select_n_o,
  output logic io_space_select_n_o,
  output logic rw_o,
  output logic transfer_strobe_n_o,
  input wire logic ready_i,
  output logic clock_out_primary_o,
  output logic clock_out_secondary_o,
  input wire logic branch_test_input_n_i,
  output logic external_flag_output_o
);

  ////////////////////////////////////////////////////////////////////////////
  // phase generator

  phase_if ph ();

  quarter_phase_gen u_phase (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ph(ph.source)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    bus_state_type state;
    access_type kind;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic ext;
    logic [1:0] cycles_left;
    logic waiting;
    logic test_low;
    // registered pin and core outputs
    logic [15:0] addr_pin;
    logic [15:0] data_pin;
    logic data_oe;
    logic ds_n;
    logic ps_n;
    logic is_n;
    logic rw;
    logic strobe_n;
    logic ck1;
    logic ck2;
    logic flag;
    logic branch_taken;
    logic req_ready;
    logic done;
    logic [15:0] rdata;
  } unit_state_type;

  unit_state_type cur;
  unit_state_type next_cur;
  phase_type nq;
  logic drive;
  logic is_write;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    next_cur = cur;
    nq = next_quarter(ph.quarter);
    next_cur.done = 1'b0;
    next_cur.branch_taken = 1'b0;

    // request taken only at the last quarter so the access starts on Q1
    if (cur.state == BUS_IDLE) begin
      if (req_valid_i && ph.last_quarter) begin
        next_cur.state = BUS_ACTIVE;
        next_cur.kind = req_kind_i;
        next_cur.wdata = req_wdata_i;
        next_cur.waiting = 1'b0;
        // ports live only on the external bus, one word each
        if (req_kind_i == PORT_IN || req_kind_i == PORT_OUT) begin
          next_cur.ext = 1'b1;
          next_cur.addr = {PORT_ADDR_PAD, req_addr_i[PORT_BITS-1:0]};
        end else begin
          next_cur.ext = req_external_i;
          next_cur.addr = req_addr_i;
        end
        // on-chip work costs one machine cycle and never waits
        if ((req_kind_i == PORT_IN || req_kind_i == PORT_OUT) || req_external_i) begin
          next_cur.cycles_left = access_cost(req_kind_i, req_repeat_i, prog_external_i);
        end else begin
          next_cur.cycles_left = ONE_CYCLE;
        end
      end
    end else if (ph.last_quarter) begin
      // machine-cycle boundary: count down, stretch, or finish
      if (cur.cycles_left != ONE_CYCLE) begin
        next_cur.cycles_left = cur.cycles_left - 2'h1;
      end else if (cur.ext && !ready_i) begin
        next_cur.waiting = 1'b1;
      end else begin
        next_cur.state = BUS_IDLE;
        next_cur.done = 1'b1;
        next_cur.waiting = 1'b0;
        if (cur.ext && (cur.kind == PROG_FETCH || cur.kind == DATA_READ || cur.kind == PORT_IN)) begin
          next_cur.rdata = data_i;
        end
      end
    end

    // test input caught at the end of the fourth quarter
    if (ph.quarter == Q4) begin
      next_cur.test_low = !branch_test_input_n_i;
    end
    if (branch_on_test_low_instr_i) begin
      next_cur.branch_taken = cur.test_low;
    end

    // flag pin; a set in the same cycle as a clear wins
    if (set_flag_instr_i) begin
      next_cur.flag = 1'b1;
    end else if (clear_flag_instr_i) begin
      next_cur.flag = 1'b0;
    end

    // pin values for the coming cycle
    drive = (next_cur.state == BUS_ACTIVE) && next_cur.ext;
    is_write = (next_cur.kind == DATA_WRITE) || (next_cur.kind == PORT_OUT);
    next_cur.addr_pin = drive ? next_cur.addr : cur.addr_pin;
    next_cur.data_pin = (drive && is_write) ? next_cur.wdata : cur.data_pin;
    next_cur.data_oe = drive && is_write;
    next_cur.ds_n = !(drive && (next_cur.kind == DATA_READ || next_cur.kind == DATA_WRITE));
    next_cur.ps_n = !(drive && next_cur.kind == PROG_FETCH);
    next_cur.is_n = !(drive && (next_cur.kind == PORT_IN || next_cur.kind == PORT_OUT));
    next_cur.rw = !(drive && is_write);
    // strobe in the final machine cycle from Q2, unbroken across waits
    next_cur.strobe_n = !(drive && next_cur.cycles_left == ONE_CYCLE && (nq != Q1 || next_cur.waiting));
    // primary high in Q3,Q4; secondary high in Q2,Q3
    next_cur.ck1 = (nq == Q3) || (nq == Q4);
    next_cur.ck2 = (nq == Q2) || (nq == Q3);
    next_cur.req_ready = (next_cur.state == BUS_IDLE) && (nq == Q4);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur.state <= BUS_IDLE;
      cur.kind <= PROG_FETCH;
      cur.addr <= ADDR_RESET;
      cur.wdata <= DATA_RESET;
      cur.ext <= 1'b0;
      cur.cycles_left <= ONE_CYCLE;
      cur.waiting <= 1'b0;
      cur.test_low <= 1'b0;
      cur.addr_pin <= ADDR_RESET;
      cur.data_pin <= DATA_RESET;
      cur.data_oe <= 1'b0;
      cur.ds_n <= 1'b1;
      cur.ps_n <= 1'b1;
      cur.is_n <= 1'b1;
      cur.rw <= 1'b1;
      cur.strobe_n <= 1'b1;
      cur.ck1 <= 1'b0;
      cur.ck2 <= 1'b0;
      cur.flag <= FLAG_RESET;
      cur.branch_taken <= 1'b0;
      cur.req_ready <= 1'b0;
      cur.done <= 1'b0;
      cur.rdata <= DATA_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign addr_o = cur.addr_pin;
  assign data_o = cur.data_pin;
  assign data_oe_o = cur.data_oe;
  assign data_space_select_n_o = cur.ds_n;
  assign program_space_select_n_o = cur.ps_n;
  assign io_space_select_n_o = cur.is_n;
  assign rw_o = cur.rw;
  assign transfer_strobe_n_o = cur.strobe_n;
  assign clock_out_primary_o = cur.ck1;
  assign clock_out_secondary_o = cur.ck2;
  assign external_flag_output_o = cur.flag;
  assign branch_taken_o = cur.branch_taken;
  assign req_ready_o = cur.req_ready;
  assign done_o = cur.done;
  assign rdata_o = cur.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers: access length and wait count

  logic [7:0] acc_len;
  logic [WAIT_WIDTH-1:0] wait_cnt;
  logic acc_repeat;
  logic acc_prog_ext;

  // length counts from the first active cycle through the last active cycle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_len <= 8'h00;
      wait_cnt <= '0;
      acc_repeat <= 1'b0;
      acc_prog_ext <= 1'b0;
    end else if (cur.state == BUS_IDLE && next_cur.state == BUS_ACTIVE) begin
      acc_len <= 8'h00;
      wait_cnt <= '0;
      acc_repeat <= req_repeat_i;
      acc_prog_ext <= prog_external_i;
    end else if (cur.state == BUS_ACTIVE) begin
      acc_len <= acc_len + 8'h01;
      if (next_cur.waiting && !cur.waiting) begin
        wait_cnt <= wait_cnt + 8'h01;
      end else if (cur.waiting && ph.quarter == Q4 && next_cur.waiting) begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  AST_INTERNAL_QUIET: assert property (
    (cur.state == BUS_IDLE || !cur.ext) |-> (transfer_strobe_n_o && rw_o && !data_oe_o
      && data_space_select_n_o && program_space_select_n_o && io_space_select_n_o))
    else $error("controls or data bus active during internal access");

  AST_ONE_SPACE: assert property (
    $onehot0({!data_space_select_n_o, !program_space_select_n_o, !io_space_select_n_o}))
    else $error("more than one space select active");

  AST_WRITE_DRIVES: assert property (
    (!transfer_strobe_n_o && !rw_o) |-> data_oe_o)
    else $error("write strobe without data driven");

  AST_WAIT_HOLDS_STROBE: assert property (
    (cur.state == BUS_ACTIVE && cur.ext && cur.cycles_left == ONE_CYCLE && ph.quarter == Q4 && !ready_i)
      |=> (!transfer_strobe_n_o && !done_o) [*4])
    else $error("strobe released while ready low");

  AST_READY_ENDS: assert property (
    (!transfer_strobe_n_o && ph.quarter == Q4 && ready_i) |=> (done_o && transfer_strobe_n_o))
    else $error("access not ended after ready seen high");

  AST_READ_TWO: assert property (
    (done_o && cur.ext && cur.kind == DATA_READ) |-> (acc_len >= 8'h08))
    else $error("external data read shorter than two cycles");

  AST_PORT_CYCLES: assert property (
    (done_o && cur.kind == PORT_IN) |-> (acc_len == (acc_repeat ? 8'h04 : 8'h08) + {wait_cnt[5:0], 2'b00}))
    else $error("port input cycle count wrong");

  AST_OUT_ONE: assert property (
    (done_o && cur.kind == PORT_OUT && !acc_prog_ext) |-> (acc_len == 8'h04 + {wait_cnt[5:0], 2'b00}))
    else $error("port output with internal program not one cycle");

  AST_WRITE_CYCLES: assert property (
    (done_o && cur.ext && cur.kind == DATA_WRITE)
      |-> (acc_len == (acc_prog_ext ? 8'h08 : 8'h04) + {wait_cnt[5:0], 2'b00}))
    else $error("external data write cycle count wrong");

  AST_FULL_SPEED: assert property (
    (done_o && !cur.ext) |-> (acc_len == 8'h04))
    else $error("on-chip access not single cycle");

  AST_PRIMARY_Q3: assert property (
    $rose(clock_out_primary_o) |-> (ph.quarter == Q3 && clock_out_secondary_o))
    else $error("primary clock rise not at third quarter");

  AST_BRANCH_TEST: assert property (
    branch_on_test_low_instr_i |=> (branch_taken_o == $past(cur.test_low)))
    else $error("branch decision does not follow sampled test input");

  AST_FLAG: assert property (
    (set_flag_instr_i |=> external_flag_output_o) and (clear_flag_instr_i && !set_flag_instr_i |=> !external_flag_output_o))
    else $error("flag pin did not follow instruction");

  // pins stay put while an access runs
  AST_ADDR_HELD: assert property (
    (cur.state == BUS_ACTIVE && next_cur.state == BUS_ACTIVE) |=> $stable(addr_o))
    else $error("address pins moved during an access");

  AST_SELECT_HELD: assert property (
    (cur.state == BUS_ACTIVE && cur.ext)
      |-> !(data_space_select_n_o && program_space_select_n_o && io_space_select_n_o))
    else $error("no space select during an external access");

  AST_PORT_ADDR: assert property (
    !io_space_select_n_o |-> (addr_o[BUS_WIDTH-1:PORT_BITS] == PORT_ADDR_PAD))
    else $error("port address outside the sixteen ports");

  // quarter bookkeeping and clock pins
  AST_LAST_QUARTER: assert property (
    ph.last_quarter == (ph.quarter == Q4))
    else $error("last-quarter marker out of step with the quarter");

  AST_CLOCK_PAIR: assert property (
    $rose(clock_out_secondary_o) |-> (ph.quarter == Q2 && !clock_out_primary_o))
    else $error("secondary clock rise not at second quarter");

  // test input and flag pin only move when they are meant to
  AST_TEST_SAMPLE: assert property (
    (ph.quarter != Q4) |=> $stable(cur.test_low))
    else $error("test input latched outside the fourth quarter");

  AST_FLAG_HOLD: assert property (
    (!set_flag_instr_i && !clear_flag_instr_i) |=> $stable(external_flag_output_o))
    else $error("flag pin moved with no instruction");

  COV_WAIT: cover property (!transfer_strobe_n_o && ph.quarter == Q4 && !ready_i);
  COV_EXT_WRITE: cover property (done_o && cur.ext && cur.kind == DATA_WRITE && acc_prog_ext);
  COV_EXT_READ: cover property (done_o && cur.ext && cur.kind == DATA_READ);
  COV_PORT_REPEAT: cover property (done_o && cur.kind == PORT_IN && acc_repeat);
  COV_BRANCH: cover property (branch_taken_o);

endmodule : ext_bus_unit

// ### shared/ext_bus_pkg.sv
// constants, types and helpers shared by the external bus block
//
// Overview of operation
// - sixteen-bit data and address buses carry transfers
// - one active-low select per data, program, I/O space
// - direction output and strobe time each transfer
// - sixteen input and sixteen output word ports
// - port access two cycles, one when repeated
// - internal access: data bus released, controls high
// - slow device holds completion low on ready
// - all on-chip accesses run without wait states
// - program internal: port in two, out one
// - internal data never blocks external program fetches; here a fetch waits out an internal data cycle
// - external data read at least two cycles
// - external write one cycle, two if program external
// - four quarters; primary clock rises at third quarter
// - branch-on-test taken only while test input low
// - test input sampled at end of fourth quarter
// - flag set, cleared by instruction; reset sets high
package ext_bus_pkg;

  localparam int BUS_WIDTH = 16;
  localparam int PORT_BITS = 4;
  localparam int QUARTERS = 4;
  localparam int WAIT_WIDTH = 8;

  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [11:0] PORT_ADDR_PAD = 12'h000;
  localparam logic [1:0] ONE_CYCLE = 2'h0;
  localparam logic [1:0] TWO_CYCLES = 2'h1;
  localparam logic FLAG_RESET = 1'b1;

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_type;

  typedef enum logic [2:0] {
    PROG_FETCH,
    DATA_READ,
    DATA_WRITE,
    PORT_IN,
    PORT_OUT
  } access_type;

  typedef enum logic {BUS_IDLE, BUS_ACTIVE} bus_state_type;

  // quarter that follows the given one
  function automatic phase_type next_quarter(input phase_type q);
    phase_type r;
    r = Q1;
    unique case (q)
      Q1: r = Q2;
      Q2: r = Q3;
      Q3: r = Q4;
      Q4: r = Q1;
    endcase
    return r;
  endfunction : next_quarter

  // machine cycles minus one that an external access occupies before waits
  function automatic logic [1:0] access_cost(input access_type k, input logic rpt, input logic prog_ext);
    logic [1:0] c;
    c = ONE_CYCLE;
    unique case (k)
      PROG_FETCH: c = ONE_CYCLE;
      DATA_READ: c = TWO_CYCLES;
      DATA_WRITE: c = prog_ext ? TWO_CYCLES : ONE_CYCLE;
      PORT_IN: c = rpt ? ONE_CYCLE : TWO_CYCLES;
      PORT_OUT: c = (rpt || !prog_ext) ? ONE_CYCLE : TWO_CYCLES;
      default: c = ONE_CYCLE;
    endcase
    return c;
  endfunction : access_cost

endpackage : ext_bus_pkg

// ### shared/phase_if.sv
// quarter-phase timing shared between phase generator and bus unit
`timescale 1ns/1ns
interface phase_if;
  import ext_bus_pkg::*;
  phase_type quarter;
  logic last_quarter;
  modport source (output quarter, output last_quarter);
  modport sink (input quarter, input last_quarter);
endinterface : phase_if

// ### hdl/quarter_phase_gen.sv
// four-phase machine-cycle generator
`timescale 1ns/1ns
module quarter_phase_gen
  import ext_bus_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  phase_if.source ph
);

  typedef struct packed {
    phase_type quarter;
    logic last_quarter;
  } gen_state_type;

  gen_state_type cur;
  gen_state_type next_cur;

  // each input clock advances one quarter
  always_comb begin
    next_cur.quarter = next_quarter(cur.quarter);
    next_cur.last_quarter = (next_quarter(cur.quarter) == Q4);
  end

  // register the quarter
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur.quarter <= Q1;
      cur.last_quarter <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign ph.quarter = cur.quarter;
  assign ph.last_quarter = cur.last_quarter;

endmodule : quarter_phase_gen

// ### testbench/ext_mem_model.sv
// external memory and port model seen on the device's bus pins
`timescale 1ns/1ns
module ext_mem_model (
  input wire logic mclk_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic prog_sel_n_i,
  input wire logic io_sel_n_i,
  input wire logic rw_i,
  input wire logic strobe_n_i,
  input wire logic [3:0] waits_i,
  output logic ready_o,
  output logic [15:0] data_o
);
  logic [15:0] mem [0:63];
  logic [15:0] last = 16'h0000;
  logic [5:0] idx;
  int cnt = 0;
  ////////////////////////////////////////
  // word slot from the active space and the low address bits
  assign idx = {(!io_sel_n_i ? 2'h2 : (!prog_sel_n_i ? 2'h1 : 2'h0)), addr_i[3:0]};
  // slow device: ready stays low for the requested wait states
  assign ready_o = (cnt >= 2 + 4 * waits_i);
  // word shown only under a read strobe, a changing pattern otherwise
  assign data_o = (strobe_n_i === 1'b0 && rw_i === 1'b1) ? mem[idx] : ~last;
  // known contents so reads of unwritten words can be predicted
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'hC000 + 16'(i);
    end
  end
  // count strobe-low cycles and store a write at its closing edge
  always @(posedge mclk_i) begin
    last <= data_o;
    cnt <= strobe_n_i ? 0 : cnt + 1;
    if (!strobe_n_i && !rw_i && ready_o) begin
      mem[idx] <= data_i;
    end
  end
endmodule : ext_mem_model

// ### testbench/ext_bus_unit_tb.sv
// self-checking bench for the external bus unit
`timescale 1ns/1ns
module ext_bus_unit_tb;
  import ext_bus_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  access_type req_kind_i = DATA_READ;
  logic [15:0] req_addr_i = 16'h0000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic req_external_i = 1'b0;
  logic req_repeat_i = 1'b0;
  logic prog_external_i = 1'b0;
  logic set_flag_instr_i = 1'b0;
  logic clear_flag_instr_i = 1'b0;
  logic branch_on_test_low_instr_i = 1'b0;
  logic branch_test_input_n_i = 1'b1;
  logic [3:0] waits = 4'h0;
  logic req_ready_o, done_o, branch_taken_o, data_oe_o, rw_o, ready_i, transfer_strobe_n_o;
  logic data_space_select_n_o, program_space_select_n_o, io_space_select_n_o;
  logic clock_out_primary_o, clock_out_secondary_o, external_flag_output_o;
  logic [15:0] rdata_o, addr_o, data_o, mem_data, data_i, rd;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  ////////////////////////////////////////
  always #4 mclk_i = ~mclk_i;
  // wire level: the device while it drives, else the model
  assign data_i = data_oe_o ? data_o : mem_data;
  ext_bus_unit ext_bus_unit_i (.mclk_i, .arst_n_i, .req_valid_i, .req_kind_i, .req_addr_i, .req_wdata_i,
    .req_external_i, .req_repeat_i, .prog_external_i, .set_flag_instr_i, .clear_flag_instr_i,
    .branch_on_test_low_instr_i, .req_ready_o, .done_o, .rdata_o, .branch_taken_o, .addr_o, .data_i, .data_o,
    .data_oe_o, .data_space_select_n_o, .program_space_select_n_o, .io_space_select_n_o, .rw_o,
    .transfer_strobe_n_o, .ready_i, .clock_out_primary_o, .clock_out_secondary_o, .branch_test_input_n_i,
    .external_flag_output_o);
  ext_mem_model ext_mem_model_i (.mclk_i, .addr_i(addr_o), .data_i(data_i), .prog_sel_n_i(program_space_select_n_o),
    .io_sel_n_i(io_space_select_n_o), .rw_i(rw_o), .strobe_n_i(transfer_strobe_n_o), .waits_i(waits),
    .ready_o(ready_i), .data_o(mem_data));
  ////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // settle in a cycle where the unit will take a request
  task automatic wait_take();
    @(negedge mclk_i);
    while (req_ready_o !== 1'b1) @(negedge mclk_i);
  endtask : wait_take
  // one access: drive, watch the pins, judge cost and pin activity
  task automatic acc(input access_type k, input logic [15:0] a, input logic [15:0] w, input logic ext,
    input logic rpt, input logic pext, input logic [3:0] wt, input int base, output logic [15:0] got);
    int n;
    int sl;
    logic [2:0] sel;
    logic wr;
    logic io;
    logic [15:0] ad;
    logic [15:0] a0;
    io = (k == PORT_IN) || (k == PORT_OUT);
    n = 0;
    sl = 0;
    sel = 3'h0;
    wr = 1'b0;
    ad = 16'h0000;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_kind_i <= k;
    req_addr_i <= a;
    req_wdata_i <= w;
    req_external_i <= ext;
    req_repeat_i <= rpt;
    prog_external_i <= pext;
    waits <= wt;
    wait_take();
    a0 = addr_o;
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    do begin
      @(negedge mclk_i);
      n++;
      if (n == 1) ad = addr_o;
      sel = sel | ~{data_space_select_n_o, program_space_select_n_o, io_space_select_n_o};
      sl += (transfer_strobe_n_o === 1'b0);
      wr = wr | (~rw_o & data_oe_o);
    end while (done_o !== 1'b1 && n < 300);
    got = rdata_o;
    chk("cycles", 16'(n - 1), 16'(4 * (base + wt)));
    chk("select", sel, (ext || io) ? (io ? 3'h1 : (k == PROG_FETCH ? 3'h2 : 3'h4)) : 3'h0);
    chk("strobe", 16'(sl), (ext || io) ? 16'(3 + 4 * wt) : 16'h0000);
    chk("write", wr, (ext || io) && (k == DATA_WRITE || k == PORT_OUT));
    chk("addr", ad, (ext || io) ? (io ? {12'h000, a[3:0]} : a) : a0);
  endtask : acc
  // memory costs across both program placements, with wait states
  task automatic t_mem();
    acc(DATA_WRITE, 16'h0123, 16'hBEEF, 1'b1, 1'b0, 1'b0, 4'h0, 1, rd);
    acc(DATA_WRITE, 16'h0124, 16'h1234, 1'b1, 1'b0, 1'b1, 4'h1, 2, rd);
    acc(DATA_READ, 16'h0123, 16'h0000, 1'b1, 1'b0, 1'b0, 4'h2, 2, rd);
    chk("read", rd, 16'hBEEF);
    acc(DATA_READ, 16'h0124, 16'h0000, 1'b1, 1'b0, 1'b1, 4'h0, 2, rd);
    chk("read", rd, 16'h1234);
    acc(PROG_FETCH, 16'h0007, 16'h0000, 1'b1, 1'b0, 1'b1, 4'h1, 1, rd);
    chk("fetch", rd, 16'hC017);
    acc(DATA_READ, 16'h0055, 16'h0000, 1'b0, 1'b0, 1'b0, 4'h0, 1, rd);
    acc(DATA_WRITE, 16'h0056, 16'h7777, 1'b0, 1'b0, 1'b1, 4'h0, 1, rd);
  endtask : t_mem
  // every port out then back in, plain and repeated
  task automatic t_ports();
    for (int p = 0; p < 16; p++) begin
      acc(PORT_OUT, 16'(p), 16'hA000 + 16'(p), 1'b0, p[0], 1'b1, 4'h0, p[0] ? 1 : 2, rd);
      acc(PORT_IN, 16'h0FF0 | 16'(p), 16'h0000, 1'b0, p[1], 1'b0, 4'h0, p[1] ? 1 : 2, rd);
      chk("port", rd, 16'hA000 + 16'(p));
    end
    acc(PORT_OUT, 16'h0003, 16'h5555, 1'b1, 1'b0, 1'b0, 4'h0, 1, rd);
  endtask : t_ports
  task automatic flag_op(input logic s, input logic c, input logic exp);
    @(posedge mclk_i);
    set_flag_instr_i <= s;
    clear_flag_instr_i <= c;
    @(posedge mclk_i);
    set_flag_instr_i <= 1'b0;
    clear_flag_instr_i <= 1'b0;
    @(negedge mclk_i);
    chk("flag", external_flag_output_o, exp);
  endtask : flag_op
  task automatic branch_op(input logic lvl, input logic exp);
    @(posedge mclk_i);
    branch_test_input_n_i <= lvl;
    repeat (8) @(posedge mclk_i);
    branch_on_test_low_instr_i <= 1'b1;
    @(posedge mclk_i);
    branch_on_test_low_instr_i <= 1'b0;
    @(negedge mclk_i);
    chk("branch", branch_taken_o, exp);
  endtask : branch_op
  // quarter pattern of both clock outputs starting in an idle fourth quarter
  task automatic t_clocks();
    logic [3:0] p;
    logic [3:0] s;
    wait_take();
    for (int i = 0; i < 4; i++) begin
      p = {p[2:0], clock_out_primary_o};
      s = {s[2:0], clock_out_secondary_o};
      @(negedge mclk_i);
    end
    chk("primary", p, 4'h9);
    chk("secondary", s, 4'h3);
  endtask : t_clocks
  ////////////////////////////////////////
  // cut a hang short
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk("flag", external_flag_output_o, 1'b1);
    chk("idle", {data_space_select_n_o, program_space_select_n_o, io_space_select_n_o,
      transfer_strobe_n_o, rw_o, data_oe_o}, 6'h3E);
    $display("test reset done");
    t_clocks();
    $display("test clocks done");
    t_mem();
    $display("test memory done");
    t_ports();
    $display("test ports done");
    flag_op(1'b0, 1'b1, 1'b0);
    flag_op(1'b1, 1'b0, 1'b1);
    flag_op(1'b0, 1'b1, 1'b0);
    flag_op(1'b1, 1'b1, 1'b1);
    $display("test flag done");
    branch_op(1'b0, 1'b1);
    branch_op(1'b1, 1'b0);
    branch_op(1'b0, 1'b1);
    $display("test branch done");
    close_out();
  end
endmodule : ext_bus_unit_tb
